// *** rtl/tbpd_pkg.sv ***
// Constants shared by the texture block partition decoder
package tbpd_pkg;
  // Register map, byte addresses
  localparam logic [11:0] CTRL_OFS     = 12'h000;
  localparam logic [11:0] STAT_OFS     = 12'h004;
  localparam logic [11:0] ILLCNT_OFS   = 12'h008;
  // Control field positions and reset value
  localparam int          CTRL_HDR_BIT = 0;
  localparam int          CTRL_RED_BIT = 1;
  localparam int          CTRL_SRGB_BIT = 2;
  localparam logic [2:0]  CTRL_RST     = 3'h0;
  // Constant-colour block layout
  localparam logic [8:0]  VOID_TAG     = 9'h1FC;
  localparam int          VOID_DR_BIT  = 9;
  localparam int          VOID_S_LO    = 10;
  localparam int          VOID_CRD_W   = 9;
  localparam int          VOID_RGBA_LO = 64;
  // Extent divisors applied downstream when normalising
  localparam int          EXT_DIV_2D   = (2 ** 13) - 1;
  localparam int          EXT_DIV_3D   = (2 ** 9) - 1;
  // Error colours, packed {A,B,G,R}
  localparam logic [63:0] ERR_LDR      = 64'h00FF_00FF_0000_00FF;
  localparam logic [63:0] ERR_HDR      = 64'hFFFF_FFFF_FFFF_FFFF;
  // Partition pattern constants
  localparam int          TINY_TEXELS  = 31;
  localparam int          PART_SEED_STEP = 1024;
  localparam logic [31:0] SCR_MUL      = 32'h0000_000F;
  localparam logic [3:0]  NIB_MASK     = 4'hF;
  localparam logic [2:0]  SH_SMALL     = 3'h4;
  localparam logic [2:0]  SH_MID       = 3'h5;
  localparam logic [2:0]  SH_BIG       = 3'h6;
  // Hash nibble offsets for the first eleven fields
  localparam logic [10:0][4:0] SEED_OFS = {5'd26, 5'd22, 5'd18, 5'd28,
    5'd24, 5'd20, 5'd16, 5'd12, 5'd8, 5'd4, 5'd0};
  // Encoding limits
  localparam int          MAX_IDX      = 64;
  localparam int          MAX_IDX_BITS = 96;
  localparam int          MIN_IDX_BITS = 24;
  localparam int          MAX_EP_INTS  = 18;
  localparam int          BLK_BITS     = 128;
  localparam int          CCS_W        = 2;
  // Endpoint formats allowed in the reduced profile
  localparam logic [15:0] RED_CEM_OK   = 16'h3773;
  // Endpoint value ranges, smallest first: {trit, quint, bits}
  localparam int          NUM_RANGES   = 21;
  localparam logic [20:0][5:0] RANGE_TBL = {6'h08, 6'h26, 6'h15,
    6'h07, 6'h25, 6'h14, 6'h06, 6'h24, 6'h13, 6'h05, 6'h23, 6'h12,
    6'h04, 6'h22, 6'h11, 6'h03, 6'h21, 6'h10, 6'h02, 6'h20, 6'h01};
endpackage

// *** rtl/tbpd_decode.sv ***
// Partition, range, constant-colour and illegal-block decoder with APB
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module tbpd_decode (
  input  wire logic         clock,
  input  wire logic         rst_b,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic              pready,
  output logic [31:0]       prdata,
  output logic              pslverr,
  input  wire logic         req_valid,
  input  wire logic [127:0] blk_data,
  input  wire logic [3:0]   tex_x,
  input  wire logic [3:0]   tex_y,
  input  wire logic [3:0]   tex_z,
  input  wire logic [3:0]   fp_x,
  input  wire logic [3:0]   fp_y,
  input  wire logic [3:0]   fp_z,
  input  wire logic         is_3d,
  input  wire logic [1:0]   part_cnt_m1,
  input  wire logic [9:0]   part_seed,
  input  wire logic         dual_plane,
  input  wire logic         reserved_mode,
  input  wire logic [3:0]   grid_n,
  input  wire logic [3:0]   grid_m,
  input  wire logic [3:0]   grid_q,
  input  wire logic [7:0]   idx_bits,
  input  wire logic [3:0]   extra_mode_bits,
  input  wire logic [3:0]   endpoint_pair_count,
  input  wire logic [7:0]   remaining_bits,
  input  wire logic [15:0]  endpoint_mode,
  input  wire logic [3:0]   part_hdr,
  output logic              out_valid,
  output logic [1:0]        part_idx,
  output logic [4:0]        ep_range,
  output logic              blk_illegal,
  output logic              tex_err,
  output logic [3:0]        plane1_mask,
  output logic              const_color,
  output logic              const_hdr,
  output logic [63:0]       color_out,
  output logic              unorm8_out
);
  import tbpd_pkg::*;

  logic [2:0]  ctrl_r;
  logic [15:0] illcnt_r;
  logic        hdr_op, red_prof, acc, hit;

  assign hdr_op   = ctrl_r[CTRL_HDR_BIT] & ~ctrl_r[CTRL_RED_BIT];
  assign red_prof = ctrl_r[CTRL_RED_BIT];
  assign acc      = psel & penable & ~pready;
  assign hit      = (paddr == CTRL_OFS) | (paddr == STAT_OFS)
                  | (paddr == ILLCNT_OFS);

  // APB slave: answer on the second access cycle, pready from a flop
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc;
      pslverr <= acc & ~hit;
      prdata  <= 32'h0000_0000;
      if (acc && !pwrite) begin
        unique case (paddr)
          CTRL_OFS:   prdata <= {29'h0, ctrl_r};
          STAT_OFS:   prdata <= {21'h0, blk_illegal, tex_err,
                                 part_idx, ep_range, out_valid,
                                 const_color};
          ILLCNT_OFS: prdata <= {16'h0, illcnt_r};
          default:    prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control register; write lands at the completing edge
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ctrl_r <= CTRL_RST;
    end else if (psel && penable && pready && pwrite
                 && paddr == CTRL_OFS) begin
      ctrl_r <= pwdata[2:0];
    end
  end

  // Partition selection, straight from the pattern algorithm
  function automatic logic [31:0] scramble(input logic [31:0] s);
    logic [31:0] p;
    p = s;
    p = p ^ (p * SCR_MUL);
    p = p - (p << 17);
    p = p + (p << 7);
    p = p + (p << 4);
    p = p ^ (p >> 5);
    p = p + (p << 16);
    p = p ^ (p >> 7);
    p = p ^ (p >> 3);
    p = p ^ (p << 6);
    p = p ^ (p >> 17);
    scramble = p;
  endfunction

  logic        tiny;
  logic [4:0]  px, py, pz;
  logic [31:0] rnum;
  logic [11:0][7:0] sq;
  logic [2:0]  sh1, sh2, sh3;
  logic [5:0]  sa, sb, sc, sd;
  logic [1:0]  part_nxt;

  // Small footprints sample the pattern at double spacing
  assign tiny = (32'(fp_x) * 32'(fp_y) * 32'(fp_z)) < TINY_TEXELS;
  assign px   = tiny ? {tex_x, 1'b0} : {1'b0, tex_x};
  assign py   = tiny ? {tex_y, 1'b0} : {1'b0, tex_y};
  assign pz   = tiny ? {tex_z, 1'b0} : {1'b0, tex_z};
  assign rnum = scramble(32'(part_seed)
              + 32'(part_cnt_m1) * 32'(PART_SEED_STEP));

  // Shift choice depends on seed bits 0, 1, 4 and three partitions
  always_comb begin
    logic three;
    three = (part_cnt_m1 == 2'd2);
    if (part_seed[0]) begin
      sh1 = part_seed[1] ? SH_SMALL : SH_MID;
      sh2 = three ? SH_BIG : SH_MID;
    end else begin
      sh1 = three ? SH_BIG : SH_MID;
      sh2 = part_seed[1] ? SH_SMALL : SH_MID;
    end
    sh3 = part_seed[4] ? sh1 : sh2;
  end

  // Nibble fields squared and shifted; the last wraps around bit 31
  for (genvar i = 0; i < 12; i++) begin : g_seed
    logic [3:0] nib;
    logic [7:0] sqr;
    logic [2:0] sh;
    if (i == 11) begin : g_wrap
      assign nib = (rnum[31:30] | {rnum[1:0], 2'b00}) & NIB_MASK;
    end else begin : g_ofs
      assign nib = 4'(rnum >> SEED_OFS[i]) & NIB_MASK;
    end
    assign sqr = 8'(nib) * 8'(nib);
    assign sh  = (i >= 8) ? sh3 : ((i % 2) == 0 ? sh1 : sh2);
    assign sq[i] = sqr >> sh;
  end

  // Weighted sums, the unused partitions forced to zero
  always_comb begin
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] c;
    logic [31:0] d;
    a  = 32'(sq[0]) * 32'(px) + 32'(sq[1]) * 32'(py)
       + 32'(sq[10]) * 32'(pz) + (rnum >> 14);
    b  = 32'(sq[2]) * 32'(px) + 32'(sq[3]) * 32'(py)
       + 32'(sq[11]) * 32'(pz) + (rnum >> 10);
    c  = 32'(sq[4]) * 32'(px) + 32'(sq[5]) * 32'(py)
       + 32'(sq[8]) * 32'(pz) + (rnum >> 6);
    d  = 32'(sq[6]) * 32'(px) + 32'(sq[7]) * 32'(py)
       + 32'(sq[9]) * 32'(pz) + (rnum >> 2);
    sa = a[5:0];
    sb = b[5:0];
    sc = (part_cnt_m1 < 2'd2) ? 6'h00 : c[5:0];
    sd = (part_cnt_m1 < 2'd3) ? 6'h00 : d[5:0];
  end

  // Ties resolve toward the lower partition number
  always_comb begin
    if (part_cnt_m1 == 2'd0) begin
      part_nxt = 2'd0;
    end else if (sa >= sb && sa >= sc && sa >= sd) begin
      part_nxt = 2'd0;
    end else if (sb >= sc && sb >= sd) begin
      part_nxt = 2'd1;
    end else if (sc >= sd) begin
      part_nxt = 2'd2;
    end else begin
      part_nxt = 2'd3;
    end
  end

  // Endpoint range: largest whose encoded size fits the bits left
  logic [4:0]  range_nxt;
  logic [5:0]  ep_ints;
  always_comb begin
    logic [15:0] need;
    need      = 16'h0000;
    ep_ints   = {1'b0, endpoint_pair_count, 1'b0};
    range_nxt = 5'd0;
    for (int r = 0; r < NUM_RANGES; r++) begin
      need = 16'((16'(ep_ints) * 16'd8 * 16'(RANGE_TBL[r][5]) + 16'd4)
           / 16'd5)
           + 16'((16'(ep_ints) * 16'd7 * 16'(RANGE_TBL[r][4]) + 16'd2)
           / 16'd3)
           + 16'(ep_ints) * 16'(RANGE_TBL[r][3:0]);
      if (need <= 16'(remaining_bits)) begin
        range_nxt = 5'(r);
      end
    end
  end

  // Constant-colour block fields
  logic        is_void, void_all1, void_bad;
  logic [5:0][8:0] crd;
  assign is_void = (blk_data[8:0] == VOID_TAG);
  for (genvar k = 0; k < 6; k++) begin : g_crd
    assign crd[k] = blk_data[VOID_S_LO + k * VOID_CRD_W +: VOID_CRD_W];
  end
  assign void_all1 = &crd;
  // Unsigned low/high compare; reduced profile skips the check
  assign void_bad = is_void & ~void_all1 & ~red_prof
                  & ((crd[0] >= crd[1]) | (crd[2] >= crd[3])
                  | (crd[4] >= crd[5]));

  // Illegal encodings of the normal block
  logic [12:0] num_idx;
  logic        enc_bad, ill_nxt, cem_bad, err_nxt;
  assign num_idx = (13'(grid_n) * 13'(grid_m) * 13'(grid_q)) << dual_plane;
  assign enc_bad = reserved_mode
    | (num_idx > 13'(MAX_IDX))
    | (idx_bits > 8'(MAX_IDX_BITS))
    | (idx_bits < 8'(MIN_IDX_BITS))
    | (grid_n > fp_x) | (grid_m > fp_y) | (grid_q > fp_z)
    | (ep_ints > 6'(MAX_EP_INTS))
    | (16'(remaining_bits) * 16'd5 < 16'(ep_ints) * 16'd13)
    | (dual_plane & (part_cnt_m1 == 2'd3))
    | (is_3d & (grid_q != 4'd1))
    | (red_prof & is_3d);
  assign ill_nxt = is_void ? (void_bad | (red_prof & is_3d))
                           : enc_bad;
  // Reduced profile refuses formats outside the LDR list
  assign cem_bad = red_prof
                 & ~RED_CEM_OK[endpoint_mode[4 * part_nxt +: 4]];
  // Texel error: block illegal, HDR void or HDR partition in LDR, or refused endpoint format
  assign err_nxt = ill_nxt
    | (is_void & blk_data[VOID_DR_BIT] & ~hdr_op)
    | (~is_void & ~hdr_op & part_hdr[part_nxt])
    | (~is_void & cem_bad);

  // Dual-plane selector read just below index and extra mode bits
  logic [6:0] ccs_pos;
  logic [1:0] component_plane_selector;
  assign ccs_pos = 7'(BLK_BITS - CCS_W) - 7'(idx_bits)
                 - 7'(extra_mode_bits);
  assign component_plane_selector     = blk_data[ccs_pos +: 2];

  // Result stage: every output straight from a flop
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      out_valid   <= 1'b0;
      part_idx    <= 2'd0;
      ep_range    <= 5'd0;
      blk_illegal <= 1'b0;
      tex_err     <= 1'b0;
      plane1_mask <= 4'h0;
      const_color <= 1'b0;
      const_hdr   <= 1'b0;
      color_out   <= 64'h0000_0000_0000_0000;
      unorm8_out  <= 1'b0;
    end else begin
      out_valid   <= req_valid;
      if (req_valid) begin
        part_idx    <= is_void ? 2'd0 : part_nxt;
        ep_range    <= is_void ? 5'd0 : range_nxt;
        blk_illegal <= ill_nxt;
        tex_err     <= err_nxt;
        // Second index goes to one component only when dual
        plane1_mask <= (dual_plane && !is_void) ? (4'h1 << component_plane_selector)
                                                : 4'h0;
        const_color <= is_void & ~err_nxt;
        const_hdr   <= is_void & blk_data[VOID_DR_BIT];
        // Error colour wins; normal blocks leave colour to later stages
        color_out   <= err_nxt ? (hdr_op ? ERR_HDR : ERR_LDR)
                     : is_void ? blk_data[VOID_RGBA_LO +: 64]
                     : 64'h0000_0000_0000_0000;
        unorm8_out  <= red_prof & ctrl_r[CTRL_SRGB_BIT];
      end
    end
  end

  // Illegal block counter, saturating so software sees a ceiling
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      illcnt_r <= 16'h0000;
    end else if (req_valid && ill_nxt && illcnt_r != 16'hFFFF) begin
      illcnt_r <= illcnt_r + 16'h0001;
    end
  end

  // Checks on the result stage and the APB handshake
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence s_dual_req;
    req_valid && dual_plane && !is_void;
  endsequence

  AST_VALID_LAT: assert property (
    req_valid |=> out_valid) else $error("valid not one cycle later");
  AST_SINGLE_PLANE: assert property (
    req_valid && !dual_plane |=> plane1_mask == 4'h0)
    else $error("plane mask set without dual plane");
  AST_DUAL_SEL: assert property (
    s_dual_req ##0 (component_plane_selector == 2'd3) |=> plane1_mask == 4'h8)
    else $error("alpha not on second index");
  AST_VOID_HDR: assert property (
    req_valid && is_void && blk_data[VOID_DR_BIT] && !hdr_op
    |=> tex_err && !const_color) else $error("HDR void not error");
  AST_DUAL_FOUR: assert property (
    s_dual_req ##0 (part_cnt_m1 == 2'd3) |=> blk_illegal)
    else $error("dual plane with four partitions passed");
  AST_ERR_LDR: assert property (
    out_valid && tex_err && !$past(hdr_op) |-> color_out == ERR_LDR)
    else $error("wrong LDR error colour");
  AST_IDX_MAX: assert property (
    req_valid && !is_void && num_idx > 13'd64 |=> blk_illegal)
    else $error("too many indexes passed");
  AST_EP_MAX: assert property (
    req_valid && !is_void && ep_ints > 6'd18 |=> blk_illegal)
    else $error("too many endpoint integers passed");
  AST_TWO_PART: assert property (
    req_valid && part_cnt_m1 == 2'd1 |=> part_idx <= 2'd1)
    else $error("partition above count");
  AST_APB_PULSE: assert property (
    pready |=> !pready) else $error("pready longer than one cycle");
endmodule

`default_nettype wire

// *** tb/tbpd_filter_model.sv ***
// Filter-side sink model that tallies decoded texel results
`timescale 1ns/1ps
`default_nettype none
module tbpd_filter_model (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        out_valid,
  input  wire logic        tex_err,
  output logic [15:0]      res_cnt,
  output logic [15:0]      err_cnt
);
  // The filter cannot push back, so every strobe must be one texel
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      res_cnt <= 16'h0;
      err_cnt <= 16'h0;
    end else if (out_valid) begin
      res_cnt <= res_cnt + 16'h1;
      err_cnt <= err_cnt + {15'h0, tex_err};
    end
  end
endmodule
`default_nettype wire

// *** tb/tbpd_decode_tb_top.sv ***
// Self-checking bench for the texture block partition decoder
`timescale 1ns/1ps
`default_nettype none
module tbpd_decode_tb_top;
  import tbpd_pkg::*;
  logic clock = 1'h0, rst_b = 1'h0, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, req_valid = 1'h0, is_3d = 1'h0;
  logic dual_plane = 1'h0, reserved_mode = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [127:0] blk_data = 128'h0;
  logic [3:0] tex_x = 4'h0, tex_y = 4'h0, tex_z = 4'h0, fp_x = 4'h6;
  logic [3:0] fp_y = 4'h6, fp_z = 4'h1, grid_n = 4'h4, grid_m = 4'h4;
  logic [3:0] grid_q = 4'h1, extra_mode_bits = 4'h0, part_hdr = 4'h0;
  logic [3:0] endpoint_pair_count = 4'h1, plane1_mask;
  logic [1:0] part_cnt_m1 = 2'h0, part_idx;
  logic [9:0] part_seed = 10'h0;
  logic [7:0] idx_bits = 8'h30, remaining_bits = 8'h28;
  logic [15:0] endpoint_mode = 16'h0, res_cnt, err_cnt;
  logic [4:0] ep_range;
  logic [63:0] color_out, ecol;
  logic pready, pslverr, out_valid, blk_illegal, tex_err;
  logic const_color, const_hdr, unorm8_out;
  logic [127:0] bb;
  int num_checks = 0, err_total = 0, nreq = 0;
  int k, c, j, x, y, z, sm, pos;
  int sdl[5] = '{0, 3, 18, 341, 1023};
  localparam logic [63:0] COLS = 64'h1111_2222_3333_4444;

  tbpd_decode tbpd_decode_i (.clock, .rst_b, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .pslverr, .req_valid, .blk_data,
    .tex_x, .tex_y, .tex_z, .fp_x, .fp_y, .fp_z, .is_3d, .part_cnt_m1,
    .part_seed, .dual_plane, .reserved_mode, .grid_n, .grid_m, .grid_q,
    .idx_bits, .extra_mode_bits, .endpoint_pair_count, .remaining_bits,
    .endpoint_mode, .part_hdr, .out_valid, .part_idx, .ep_range,
    .blk_illegal, .tex_err, .plane1_mask, .const_color, .const_hdr,
    .color_out, .unorm8_out);
  tbpd_filter_model tbpd_filter_model_i (.clock, .rst_b, .out_valid,
    .tex_err, .res_cnt, .err_cnt);

  // Free-running 100 MHz clock
  always #5 clock = ~clock;

  task automatic complete_run();
    $display("Checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string n, input logic [63:0] e, g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_f(input string n, input logic e, g);
    chk(n, {63'h0, e}, {63'h0, g});
  endtask

  // APB transfer; the wait is bounded so a dead slave cannot hang us
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic s);
    int i;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock) penable <= 1'h1;
    for (i = 0; i < 20; i++) begin
      @(posedge clock);
      if (pready === 1'h1) break;
    end
    if (i == 20) begin
      err_total++;
      complete_run();
    end
    r = prdata;
    s = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    // One idle edge so a following call never re-drives psel at once
    @(posedge clock);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic s;
    apb(1'h1, a, d, r, s);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e,
                      input logic ee);
    logic [31:0] r;
    logic s;
    apb(1'h0, a, 32'h0, r, s);
    chk("prdata", {32'h0, e}, {32'h0, r});
    chk_f("pslverr", ee, s);
  endtask

  // Legal single-partition 6x6 block; inputs land one edge later
  task automatic base();
    blk_data <= {8{16'hA5C3}};
    {tex_x, tex_y, tex_z, is_3d} <= {12'h230, 1'h0};
    {fp_x, fp_y, fp_z, grid_n, grid_m, grid_q} <= 24'h661441;
    {dual_plane, reserved_mode, part_cnt_m1} <= 4'h0;
    {idx_bits, extra_mode_bits, endpoint_pair_count} <= 16'h3001;
    {remaining_bits, endpoint_mode, part_hdr} <= 28'h2800000;
    @(posedge clock);
  endtask

  // Result is due exactly one cycle after the request edge
  task automatic req();
    req_valid <= 1'h1;
    nreq++;
    @(posedge clock) req_valid <= 1'h0;
    @(posedge clock) chk_f("out_valid", 1'h1, out_valid);
  endtask

  task automatic vtest(input logic dr, input logic [8:0] lo, hi,
                       input logic ill, err);
    base();
    blk_data <= {COLS, {3{hi, lo}}, dr, VOID_TAG};
    req();
    chk_f("tex_err", err, tex_err);
    if (ill || !err) chk_f("blk_illegal", ill, blk_illegal);
    chk("color_out", err ? ecol : COLS, color_out);
    if (!err) chk_f("const_color", 1'h1, const_color);
  endtask

  function automatic logic [1:0] exp_part(input logic [9:0] sd,
                                          input int x, y, z, c, sm);
    logic [31:0] p;
    int s[12];
    int sh1, sh2, sh3, a, b, cc, d, i;
    if (c == 1) return 2'h0;
    if (sm) begin
      x *= 2;
      y *= 2;
      z *= 2;
    end
    p = sd + (c - 1) * 1024;
    p ^= p * 15;
    p -= p << 17;
    p += p << 7;
    p += p << 4;
    p ^= p >> 5;
    p += p << 16;
    p ^= p >> 7;
    p ^= p >> 3;
    p ^= p << 6;
    p ^= p >> 17;
    for (i = 0; i < 8; i++) s[i] = (p >> (4 * i)) & 32'hF;
    s[8] = (p >> 18) & 32'hF;
    s[9] = (p >> 22) & 32'hF;
    s[10] = (p >> 26) & 32'hF;
    s[11] = ((p >> 30) | (p << 2)) & 32'hF;
    sh1 = sd[0] ? (sd[1] ? 4 : 5) : (c == 3 ? 6 : 5);
    sh2 = sd[0] ? (c == 3 ? 6 : 5) : (sd[1] ? 4 : 5);
    sh3 = sd[4] ? sh1 : sh2;
    for (i = 0; i < 12; i++)
      s[i] = (s[i] * s[i]) >> (i > 7 ? sh3 : (i % 2 ? sh2 : sh1));
    a = (s[0] * x + s[1] * y + s[10] * z + (p >> 14)) & 63;
    b = (s[2] * x + s[3] * y + s[11] * z + (p >> 10)) & 63;
    cc = (s[4] * x + s[5] * y + s[8] * z + (p >> 6)) & 63;
    d = (s[6] * x + s[7] * y + s[9] * z + (p >> 2)) & 63;
    if (c < 4) d = 0;
    if (c < 3) cc = 0;
    if (a >= b && a >= cc && a >= d) return 2'h0;
    if (b >= cc && b >= d) return 2'h1;
    return (cc >= d) ? 2'h2 : 2'h3;
  endfunction

  // Widest range whose encoding fits the bits left over
  function automatic logic [4:0] exp_rng(input int pr, rb);
    int r, v, t, q, n;
    v = pr * 2;
    for (r = NUM_RANGES - 1; r > 0; r--) begin
      t = RANGE_TBL[r][5];
      q = RANGE_TBL[r][4];
      n = RANGE_TBL[r][3:0];
      if ((v * 8 * t + 4) / 5 + (v * 7 * q + 2) / 3 + v * n <= rb)
        return r[4:0];
    end
    return 5'h0;
  endfunction

  initial begin
    ecol = ERR_LDR;
    repeat (4) @(posedge clock);
    chk({"out_valid", "part_idx", "color_out"}, 64'h0,
        {out_valid, part_idx, color_out[60:0]});
    rst_b <= 1'h1;
    @(posedge clock);
    rchk(CTRL_OFS, 32'h0, 1'h0);
    rchk(ILLCNT_OFS, 32'h0, 1'h0);
    rchk(12'h00C, 32'h0, 1'h1);
    wr(CTRL_OFS, 32'hFFFF_FFFF);
    rchk(CTRL_OFS, 32'h7, 1'h0);
    wr(CTRL_OFS, 32'h0);
    // Partition hash: seed bits 0, 1 and 4 all exercised, tiny and 3D
    for (k = 0; k < 5; k++) for (c = 2; c < 5; c++)
      for (j = 0; j < 6; j++) begin
        sm = j >= 3;
        x = j % 4;
        y = 3 - j % 3;
        z = !sm;
        part_seed <= sdl[k][9:0];
        part_cnt_m1 <= c[1:0] - 2'h1;
        {tex_x, tex_y, tex_z} <= {x[3:0], y[3:0], z[3:0]};
        {fp_x, fp_y, fp_z, is_3d} <= sm ? 13'h0882 : 13'h0CC5;
        req();
        chk("part_idx", {62'h0, exp_part(sdl[k][9:0], x, y, z, c, sm)},
            {62'h0, part_idx});
      end
    base();
    for (k = 1; k < 10; k++) for (j = 0; j < 5; j++) begin
      c = 47 + j * 38;
      endpoint_pair_count <= k[3:0];
      remaining_bits <= c[7:0];
      req();
      chk("ep_range", {59'h0, exp_rng(k, c)}, {59'h0, ep_range});
    end
    // Selector slides down as extra mode bits grow
    for (k = 0; k < 4; k++) for (j = 0; j < 4; j++) begin
      base();
      pos = 126 - 48 - j;
      bb = j[0] ? ~{8{16'hA5C3}} : {8{16'hA5C3}};
      bb[pos +: 2] = k[1:0];
      {blk_data, dual_plane, part_cnt_m1} <= {bb, 3'h5};
      extra_mode_bits <= j[3:0];
      req();
      chk("plane1_mask", 64'h1 << k, {60'h0, plane1_mask});
    end
    base();
    req();
    chk("plane1_mask", 64'h0, {60'h0, plane1_mask});
    for (k = 1; k < 3; k++) begin
      base();
      part_hdr <= k[3:0];
      req();
      chk({"tex_err", "blk_illegal"}, {62'h0, k == 1, 1'h0},
          {62'h0, tex_err, blk_illegal});
    end
    vtest(1'h0, 9'h000, 9'h1FF, 1'h0, 1'h0);
    vtest(1'h1, 9'h000, 9'h1FF, 1'h0, 1'h1);
    vtest(1'h0, 9'h1FF, 9'h1FF, 1'h0, 1'h0);
    vtest(1'h0, 9'h100, 9'h0FF, 1'h1, 1'h1);
    vtest(1'h0, 9'h005, 9'h005, 1'h1, 1'h1);
    wr(CTRL_OFS, 32'h1);
    ecol = ERR_HDR;
    vtest(1'h1, 9'h000, 9'h1FF, 1'h0, 1'h0);
    chk_f("const_hdr", 1'h1, const_hdr);
    vtest(1'h1, 9'h005, 9'h004, 1'h1, 1'h1);
    // Reduced profile; its HDR bit must be ignored
    wr(CTRL_OFS, 32'h3);
    ecol = ERR_LDR;
    vtest(1'h0, 9'h005, 9'h005, 1'h0, 1'h0);
    vtest(1'h1, 9'h000, 9'h1FF, 1'h0, 1'h1);
    base();
    {is_3d, fp_z} <= 5'h12;
    req();
    chk_f("blk_illegal", 1'h1, blk_illegal);
    base();
    for (k = 0; k < 16; k++) begin
      endpoint_mode <= {12'h0, k[3:0]};
      req();
      chk_f("tex_err", !RED_CEM_OK[k], tex_err);
    end
    wr(CTRL_OFS, 32'h6);
    req();
    chk_f("unorm8_out", 1'h1, unorm8_out);
    wr(CTRL_OFS, 32'h4);
    req();
    chk_f("unorm8_out", 1'h0, unorm8_out);
    // Second reset mid-run, then nine illegal cases and four legal neighbours
    rst_b <= 1'h0;
    repeat (2) @(posedge clock);
    chk({"out_valid", "blk_illegal"}, 64'h0,
        {62'h0, out_valid, blk_illegal});
    rst_b <= 1'h1;
    nreq = 0;
    @(posedge clock);
    rchk(ILLCNT_OFS, 32'h0, 1'h0);
    for (k = 0; k < 13; k++) begin
      base();
      case (k)
        0: reserved_mode <= 1'h1;
        1: {grid_n, grid_m, fp_x, fp_y} <= 16'h98AA;
        2: idx_bits <= 8'h61;
        3: idx_bits <= 8'h17;
        4: grid_n <= 4'h7;
        5: {endpoint_pair_count, remaining_bits} <= 12'hAC8;
        6: {endpoint_pair_count, remaining_bits} <= 12'h414;
        7: {dual_plane, part_cnt_m1} <= 3'h7;
        8: {is_3d, grid_q, fp_z} <= 9'h122;
        9: idx_bits <= 8'h60;
        10: idx_bits <= 8'h18;
        11: {endpoint_pair_count, remaining_bits} <= 12'h415;
        default: {grid_n, endpoint_pair_count, remaining_bits} <= 16'h692F;
      endcase
      req();
      chk_f("blk_illegal", k < 9, blk_illegal);
      if (k < 9) chk("color_out", ERR_LDR, color_out);
    end
    rchk(STAT_OFS, {25'h0, exp_rng(9, 47), 2'h0}, 1'h0);
    rchk(ILLCNT_OFS, 32'h9, 1'h0);
    chk("res_cnt", 64'(nreq), {48'h0, res_cnt});
    chk("err_cnt", 64'h9, {48'h0, err_cnt});
    complete_run();
  end
endmodule
`default_nettype wire
